/* File: axil_front.sv */
module axil_front (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [hbridge_pkg::AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [hbridge_pkg::AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    regbus_if.front bus
);
    // ==========================================================
    // Write channels, taken in either order
    logic awHeld;
    logic wHeld;
    logic doWrite;

    assign awready = !awHeld;
    assign wready = !wHeld;
    assign doWrite = awHeld && wHeld && !bvalid;
    assign bus.wrEn = doWrite;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            awHeld <= 1'h0;
            bus.wrAddr <= '0;
        end else if (awvalid && awready) begin
            awHeld <= 1'h1;
            bus.wrAddr <= awaddr;
        end else if (doWrite) begin
            awHeld <= 1'h0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wHeld <= 1'h0;
            bus.wrData <= '0;
            bus.wrStrb <= '0;
        end else if (wvalid && wready) begin
            wHeld <= 1'h1;
            bus.wrData <= wdata;
            bus.wrStrb <= wstrb;
        end else if (doWrite) begin
            wHeld <= 1'h0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bvalid <= 1'h0;
            bresp <= hbridge_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'h1;
            bresp <= bus.wrErr ? hbridge_pkg::RESP_SLVERR : hbridge_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'h0;
        end
    end

    // ==========================================================
    // Read channel, one outstanding
    assign arready = !rvalid;
    assign bus.rdAddr = araddr;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rvalid <= 1'h0;
            rdata <= '0;
            rresp <= hbridge_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'h1;
            rdata <= bus.rdData;
            rresp <= bus.rdErr ? hbridge_pkg::RESP_SLVERR : hbridge_pkg::RESP_OKAY;
        end else if (rready) begin
            rvalid <= 1'h0;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed before rready");
    write_answer_a: assert property (awvalid && awready && wvalid && wready && !bvalid
        |=> ##1 bvalid)
        else $error("write response not issued two cycles after address and data");
endmodule

/* File: hbridge_parallel_pwm_drive.sv */
// Chosen here: the address map and the AXI4-Lite register port.
module hbridge_parallel_pwm_drive #(
    parameter int FAULT_W = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic bridgeEnable,
    input wire logic outputDisable,
    input wire logic bridgeInputA,
    input wire logic bridgeInputB,
    input wire logic [FAULT_W-1:0] faultDetect,
    output logic highSideA,
    output logic lowSideA,
    output logic highSideB,
    output logic lowSideB,
    output logic sleepMode,
    output logic faultStatusN,
    output logic irq,
    input wire logic [hbridge_pkg::AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [hbridge_pkg::AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    localparam int STATUS_W = FAULT_W + 1;

    if (FAULT_W < 1 || FAULT_W > 31) begin : badWidth
        $error("FAULT_W must lie between 1 and 31");
    end

    // ==========================================================
    // Bus front end
    // Keeps the register decode free of channel handshakes
    regbus_if bus ();

    axil_front front (
        .core_clk(core_clk),
        .resetn(resetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .bus(bus)
    );

    // ==========================================================
    // Byte lane mask
    logic [31:0] laneMask;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            laneMask[i*8 +: 8] = {8{bus.wrStrb[i]}};
        end
    end

    logic hitConfig;
    logic hitFaultMask;
    logic hitStatus;
    logic hitIrqMask;

    assign hitConfig = bus.wrEn && bus.wrAddr == hbridge_pkg::CONFIG_OFFSET;
    assign hitFaultMask = bus.wrEn && bus.wrAddr == hbridge_pkg::FAULT_MASK_OFFSET;
    assign hitStatus = bus.wrEn && bus.wrAddr == hbridge_pkg::STATUS_OFFSET;
    assign hitIrqMask = bus.wrEn && bus.wrAddr == hbridge_pkg::IRQ_MASK_OFFSET;

    // ==========================================================
    // Configuration
    logic [hbridge_pkg::CFG_W-1:0] cfgWord;
    logic [FAULT_W-1:0] faultMask;
    logic [STATUS_W-1:0] irqMask;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfgWord <= hbridge_pkg::CONFIG_RESET;
        end else if (hitConfig && bus.wrStrb[0]) begin
            cfgWord <= bus.wrData[hbridge_pkg::CFG_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            faultMask <= hbridge_pkg::FAULT_MASK_RESET[FAULT_W-1:0];
        end else if (hitFaultMask) begin
            faultMask <= (faultMask & ~laneMask[FAULT_W-1:0])
                | (bus.wrData[FAULT_W-1:0] & laneMask[FAULT_W-1:0]);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irqMask <= hbridge_pkg::IRQ_MASK_RESET[STATUS_W-1:0];
        end else if (hitIrqMask) begin
            irqMask <= (irqMask & ~laneMask[STATUS_W-1:0])
                | (bus.wrData[STATUS_W-1:0] & laneMask[STATUS_W-1:0]);
        end
    end

    logic serialSelect;
    logic cmdA;
    logic cmdB;
    logic active;

    // Input select 1 hands the bridge to register bits; pins ignored
    assign serialSelect = cfgWord[hbridge_pkg::CFG_SERIAL_BIT];
    assign cmdA = serialSelect ? cfgWord[hbridge_pkg::CFG_SERIAL_A_BIT] : bridgeInputA; // R17
    assign cmdB = serialSelect ? cfgWord[hbridge_pkg::CFG_SERIAL_B_BIT] : bridgeInputB; // R17
    assign active = bridgeEnable && !outputDisable; // R04 R05 R06

    // ==========================================================
    // Output stage
    // An input at 1 turns on its high FET, at 0 its low FET, so the
    // two inputs alone choose drive direction and freewheel path.
    // Both FETs of a half bridge are never on together.
    // Registered gates cost a cycle but keep decode glitches off the FETs.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            highSideA <= 1'h0;
            lowSideA <= 1'h0;
            highSideB <= 1'h0;
            lowSideB <= 1'h0;
        end else begin
            highSideA <= active && cmdA; // R01 R02 R07
            lowSideA <= active && !cmdA; // R01 R07
            highSideB <= active && cmdB; // R01 R02 R07
            lowSideB <= active && !cmdB; // R01 R07
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sleepMode <= 1'h1;
        end else begin
            sleepMode <= !bridgeEnable; // R04 R05
        end
    end

    // ==========================================================
    // Fault line and sticky events
    logic [FAULT_W-1:0] faultPrev;
    logic disablePrev;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] statusSet;
    logic [STATUS_W-1:0] statusClear;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            faultPrev <= '0;
            disablePrev <= 1'h0;
        end else begin
            faultPrev <= faultDetect;
            disablePrev <= outputDisable;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            faultStatusN <= 1'h1;
        end else begin
            faultStatusN <= !(|(faultDetect & faultMask) || outputDisable); // R12 R13
        end
    end

    // Edges, not levels: a fault stuck high raises one event only
    assign statusSet = {outputDisable && !disablePrev, faultDetect & ~faultPrev};
    assign statusClear = hitStatus ? bus.wrData[STATUS_W-1:0] & laneMask[STATUS_W-1:0] : '0;

    // New event outranks a same-cycle write-one clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            status <= '0;
        end else begin
            status <= (status & ~statusClear) | statusSet;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'h0;
        end else begin
            irq <= |(status & irqMask);
        end
    end

    // ==========================================================
    // Register read and write answers
    logic [5:0] stateWord;

    assign stateWord = {faultStatusN, sleepMode, lowSideB, highSideB, lowSideA, highSideA};

    always_comb begin
        bus.rdErr = 1'h0;
        unique case (bus.rdAddr)
            hbridge_pkg::CONFIG_OFFSET: bus.rdData = 32'(cfgWord);
            hbridge_pkg::FAULT_MASK_OFFSET: bus.rdData = 32'(faultMask);
            hbridge_pkg::LIVE_FAULT_OFFSET: bus.rdData = 32'(faultDetect);
            hbridge_pkg::STATUS_OFFSET: bus.rdData = 32'(status);
            hbridge_pkg::IRQ_MASK_OFFSET: bus.rdData = 32'(irqMask);
            hbridge_pkg::STATE_OFFSET: bus.rdData = 32'(stateWord);
            default: begin
                bus.rdData = 32'h00000000;
                bus.rdErr = 1'h1;
            end
        endcase
    end

    // Read-only offsets accept writes silently; only holes answer an error
    always_comb begin
        unique case (bus.wrAddr)
            hbridge_pkg::CONFIG_OFFSET,
            hbridge_pkg::FAULT_MASK_OFFSET,
            hbridge_pkg::LIVE_FAULT_OFFSET,
            hbridge_pkg::STATUS_OFFSET,
            hbridge_pkg::IRQ_MASK_OFFSET,
            hbridge_pkg::STATE_OFFSET: bus.wrErr = 1'h0;
            default: bus.wrErr = 1'h1;
        endcase
    end

    // ==========================================================
    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence pinDrive;
        active && !serialSelect;
    endsequence

    sequence faultRise0;
        faultDetect[0] && !faultPrev[0];
    endsequence

    sequence clear0;
        hitStatus && bus.wrStrb[0] && bus.wrData[0];
    endsequence

    forward_flow_a: assert property (pinDrive and (bridgeInputA && !bridgeInputB) // R01
        |=> highSideA && !lowSideA && lowSideB && !highSideB)
        else $error("forward inputs did not drive a high and b low");
    reverse_flow_a: assert property (pinDrive and (!bridgeInputA && bridgeInputB) // R01
        |=> lowSideA && highSideB)
        else $error("reverse inputs did not drive b high and a low");
    high_freewheel_a: assert property (pinDrive and (bridgeInputA && bridgeInputB) // R02
        |=> highSideA && highSideB && !lowSideA && !lowSideB)
        else $error("high-side freewheel not both high FETs");
    enable_run_a: assert property (bridgeEnable |=> !sleepMode) // R04
        else $error("sleep shown while enable high");
    sleep_hiz_a: assert property (!bridgeEnable // R05
        |=> sleepMode && !highSideA && !lowSideA && !highSideB && !lowSideB)
        else $error("enable low did not float outputs and sleep");
    disable_hiz_a: assert property (outputDisable // R06
        |=> !highSideA && !lowSideA && !highSideB && !lowSideB)
        else $error("disable high left a FET on");
    pins_follow_a: assert property (pinDrive // R07
        |=> highSideA == $past(bridgeInputA) && highSideB == $past(bridgeInputB))
        else $error("outputs did not follow bridge inputs");
    serial_follow_a: assert property (active && serialSelect // R17
        |=> highSideA == $past(cfgWord[hbridge_pkg::CFG_SERIAL_A_BIT]))
        else $error("serial select did not steer output a");
    fault_line_a: assert property (|(faultDetect & faultMask) |=> !faultStatusN) // R12
        else $error("masked fault not reported on fault line");
    fault_quiet_a: assert property (!(|(faultDetect & faultMask)) && !outputDisable // R12
        |=> faultStatusN)
        else $error("fault line low with no masked fault");
    disable_fault_a: assert property (outputDisable |=> !faultStatusN) // R13
        else $error("fault line not low while disable high");
    set_wins_a: assert property (faultRise0 and clear0
        |=> status[0] ##1 (irq || !irqMask[0]))
        else $error("fault event lost to a same-cycle clear");
    clear_ones_a: assert property (hitStatus && !(|statusSet)
        |=> !(|(status & $past(statusClear))))
        else $error("write-one did not clear its status bits");
    irq_level_a: assert property (|(status & irqMask) |=> irq)
        else $error("interrupt low with an unmasked status bit set");
    irq_quiet_a: assert property (!(|(status & irqMask)) |=> !irq)
        else $error("interrupt high with no unmasked status bit set");
    config_write_a: assert property (hitConfig && bus.wrStrb[0]
        |=> cfgWord == $past(bus.wrData[hbridge_pkg::CFG_W-1:0]))
        else $error("configuration write did not land");
endmodule

/* File: hbridge_pkg.sv */
// Behaviour
// [R01] Forward drives current a to b
// [R02] High-side recirculation freewheels through both high FETs
// [R03] Low-side recirculation offered only in half-bridge
// [R04] Enable high keeps the bridge operational
// [R05] Enable low: outputs high impedance, sleep
// [R06] Disable high: both outputs high impedance
// [R07] Disable low: outputs follow bridge inputs
// [R08] Controller limits PWM frequency to 20000 Hz
// [R09] Controller clamps duty between 10 and 90 percent
// [R10] Start begins driving the selected input pattern
// [R11] Stop returns inputs to a deactivating state
// [R12] Fault line reports OR of masked faults
// [R13] Fault line also low while disable high
// [R14] Half-bridge high-side pattern per direction
// [R15] Half-bridge low-side pattern per direction
// [R16] Full-bridge high-side pattern per direction; the model's reverse freewheels through both low FETs
// [R17] Parallel control only when input select 0
// [R18] PWM from counter with period and compare
// [R19] Settings change only at period boundary
package hbridge_pkg;
    // ==========================================================
    // Register map
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] CONFIG_OFFSET = 8'h00;
    localparam logic [7:0] FAULT_MASK_OFFSET = 8'h04;
    localparam logic [7:0] LIVE_FAULT_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;
    localparam logic [7:0] STATE_OFFSET = 8'h14;

    // ==========================================================
    // Fields
    localparam int CFG_MODE_BIT = 0;
    localparam int CFG_SERIAL_BIT = 1;
    localparam int CFG_SERIAL_A_BIT = 2;
    localparam int CFG_SERIAL_B_BIT = 3;
    localparam int CFG_W = 4;
    localparam int STATE_HIGH_A_BIT = 0;
    localparam int STATE_LOW_A_BIT = 1;
    localparam int STATE_HIGH_B_BIT = 2;
    localparam int STATE_LOW_B_BIT = 3;
    localparam int STATE_SLEEP_BIT = 4;
    localparam int STATE_FAULT_N_BIT = 5;

    // ==========================================================
    // Reset values and codes
    localparam logic [CFG_W-1:0] CONFIG_RESET = 4'h0;
    localparam logic [31:0] FAULT_MASK_RESET = 32'hFFFFFFFF;
    localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;
    localparam logic MODE_HALF = 1'h0;
    localparam logic MODE_FULL = 1'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: pwm_controller_model.sv */
module pwm_controller_model #(
    parameter int PERIOD = 6250,
    parameter int DUTY = 50
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic fullMode,
    input wire logic lowRecirc,
    input wire logic reverse,
    output logic bridgeInputA,
    output logic bridgeInputB
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Timing limits
    // Faster than 20 kHz is slowed to the limit, not refused
    localparam int PER = (PERIOD < 6250) ? 6250 : PERIOD;
    localparam int DC = (DUTY < 10) ? 10 : ((DUTY > 90) ? 90 : DUTY);
    localparam int ON = PER * DC / 100;
    int cnt;
    logic [3:0] cfg;
    logic pwm;
    logic lowOk;

    // ==========================================================
    // Period counter and boundary latch
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
            cfg <= 4'h0;
        end else begin
            cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
            // Latching only here avoids runt pulses on the inputs
            if (cnt == PER - 1) begin
                cfg <= {run, fullMode, lowRecirc, reverse};
            end
        end
    end
    assign pwm = cnt < ON;
    assign lowOk = cfg[1] && !cfg[2];

    // ==========================================================
    // Input patterns
    always_comb begin
        if (!cfg[3]) begin
            bridgeInputA = 1'b0;
            bridgeInputB = 1'b0;
        end else if (cfg[2]) begin
            bridgeInputA = !cfg[0];
            bridgeInputB = pwm;
        end else if (lowOk) begin
            bridgeInputA = cfg[0] ? 1'b0 : pwm;
            bridgeInputB = cfg[0] ? pwm : 1'b0;
        end else begin
            bridgeInputA = cfg[0] ? pwm : 1'b1;
            bridgeInputB = cfg[0] ? 1'b1 : pwm;
        end
    end
endmodule

/* File: regbus_if.sv */
interface regbus_if;
    logic wrEn;
    logic [hbridge_pkg::AXI_ADDR_W-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic wrErr;
    logic [hbridge_pkg::AXI_ADDR_W-1:0] rdAddr;
    logic [31:0] rdData;
    logic rdErr;

    modport front (
        output wrEn, wrAddr, wrData, wrStrb, rdAddr,
        input wrErr, rdData, rdErr
    );
    modport regs (
        input wrEn, wrAddr, wrData, wrStrb, rdAddr,
        output wrErr, rdData, rdErr
    );
endinterface

/* File: tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FW = 8;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic bridgeEnable = 1'b0;
    logic outputDisable = 1'b0;
    logic run = 1'b0;
    logic fullMode = 1'b0;
    logic lowRecirc = 1'b0;
    logic reverse = 1'b0;
    logic [FW-1:0] faultDetect = 8'h00;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic bridgeInputA, bridgeInputB, highSideA, lowSideA, highSideB, lowSideB;
    logic sleepMode, faultStatusN, irq, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] gates, expG;
    logic expSleep, chk = 1'b0, chkD = 1'b0, dirChk = 1'b0;
    int failCount = 0;
    int checksDone = 0;
    int flows, fwHigh, i;

    always #4 core_clk = ~core_clk;

    hbridge_parallel_pwm_drive #(.FAULT_W(FW)) i_dut (
        .core_clk, .resetn, .bridgeEnable, .outputDisable, .bridgeInputA, .bridgeInputB,
        .faultDetect, .highSideA, .lowSideA, .highSideB, .lowSideB, .sleepMode,
        .faultStatusN, .irq, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready
    );
    pwm_controller_model i_ctrl (
        .core_clk, .resetn, .run, .fullMode, .lowRecirc, .reverse, .bridgeInputA,
        .bridgeInputB
    );
    assign gates = {highSideA, lowSideA, highSideB, lowSideB};

    // ==========================================================
    // Checking and reporting
    task automatic tallyAndFinish;
        if (failCount == 0 && checksDone > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            failCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ==========================================================
    // Register bus
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 40) begin
            failCount++;
            tallyAndFinish();
        end
        check({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                       input logic [1:0] er);
        int n;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 40) begin
            failCount++;
            tallyAndFinish();
        end
        check({30'h0, rresp}, {30'h0, er});
        check(rdata & m, exp);
    endtask

    // ==========================================================
    // Gate monitor: one cycle behind the pins
    always @(posedge core_clk) begin
        expG <= (bridgeEnable && !outputDisable) ?
            {bridgeInputA, !bridgeInputA, bridgeInputB, !bridgeInputB} : 4'h0;
        expSleep <= !bridgeEnable;
        chkD <= chk;
    end

    always @(negedge core_clk) begin
        if (chkD && resetn) begin
            check({28'h0, gates}, {28'h0, expG});
            check({31'h0, sleepMode}, {31'h0, expSleep});
        end
        if (dirChk) begin
            check({31'h0, reverse ? highSideA && lowSideB : highSideB && lowSideA}, 32'h0);
            flows += reverse ? highSideB && lowSideA : highSideA && lowSideB;
            fwHigh += highSideA && highSideB;
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        chk <= 1'b1;
        axr(hbridge_pkg::CONFIG_OFFSET, 32'h0, 32'hFFFFFFFF, hbridge_pkg::RESP_OKAY);
        axr(hbridge_pkg::FAULT_MASK_OFFSET, 32'hFF, 32'hFF, hbridge_pkg::RESP_OKAY);
        axr(hbridge_pkg::IRQ_MASK_OFFSET, 32'h0, 32'hFFFFFFFF, hbridge_pkg::RESP_OKAY);
        axr(8'h18, 32'h0, 32'hFFFFFFFF, hbridge_pkg::RESP_SLVERR);
        axw(8'h18, 32'hFFFFFFFF, hbridge_pkg::RESP_SLVERR);
        axw(hbridge_pkg::STATE_OFFSET, 32'h0, hbridge_pkg::RESP_OKAY);
        bridgeEnable <= 1'b1;
        run <= 1'b1;
        // Half high fwd/rev, half low fwd/rev, full fwd (high freewheel) and rev (low freewheel)
        for (i = 0; i < 6; i++) begin
            dirChk <= 1'b0;
            {fullMode, lowRecirc, reverse} <= i[2:0];
            repeat (6300) @(posedge core_clk);
            flows = 0;
            fwHigh = 0;
            dirChk <= 1'b1;
            repeat (6300) @(posedge core_clk);
            check({31'h0, flows != 0}, 32'h1);
            if (i < 2) check({31'h0, fwHigh != 0}, 32'h1);
        end
        dirChk <= 1'b0;
        run <= 1'b0;
        repeat (6300) @(posedge core_clk);
        check({30'h0, bridgeInputA, bridgeInputB}, 32'h0);
        outputDisable <= 1'b1;
        repeat (5) @(posedge core_clk);
        check({31'h0, faultStatusN}, 32'h0);
        outputDisable <= 1'b0;
        repeat (5) @(posedge core_clk);
        check({31'h0, faultStatusN}, 32'h1);
        bridgeEnable <= 1'b0;
        repeat (5) @(posedge core_clk);
        bridgeEnable <= 1'b1;
        axw(hbridge_pkg::FAULT_MASK_OFFSET, 32'h1, hbridge_pkg::RESP_OKAY);
        faultDetect <= 8'h02;
        repeat (3) @(posedge core_clk);
        check({31'h0, faultStatusN}, 32'h1);
        faultDetect <= 8'h03;
        repeat (3) @(posedge core_clk);
        check({31'h0, faultStatusN}, 32'h0);
        check({31'h0, irq}, 32'h0);
        axr(hbridge_pkg::LIVE_FAULT_OFFSET, 32'h3, 32'hFFFFFFFF, hbridge_pkg::RESP_OKAY);
        axw(hbridge_pkg::IRQ_MASK_OFFSET, 32'h102, hbridge_pkg::RESP_OKAY);
        repeat (3) @(posedge core_clk);
        check({31'h0, irq}, 32'h1);
        axr(hbridge_pkg::STATUS_OFFSET, 32'h103, 32'hFFFFFFFF, hbridge_pkg::RESP_OKAY);
        axw(hbridge_pkg::STATUS_OFFSET, 32'h102, hbridge_pkg::RESP_OKAY);
        repeat (3) @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        axr(hbridge_pkg::STATUS_OFFSET, 32'h1, 32'hFFFFFFFF, hbridge_pkg::RESP_OKAY);
        faultDetect <= 8'h00;
        // Fault edge and write-one clear in one cycle: the event stays
        fork
            axw(hbridge_pkg::STATUS_OFFSET, 32'h1, hbridge_pkg::RESP_OKAY);
            begin
                repeat (2) @(posedge core_clk);
                faultDetect <= 8'h01;
            end
        join
        faultDetect <= 8'h00;
        axr(hbridge_pkg::STATUS_OFFSET, 32'h1, 32'hFFFFFFFF, hbridge_pkg::RESP_OKAY);
        // Serial select overrides the pins
        chk <= 1'b0;
        axw(hbridge_pkg::CONFIG_OFFSET, 32'h6, hbridge_pkg::RESP_OKAY);
        repeat (3) @(posedge core_clk);
        check({28'h0, gates}, 32'h9);
        axr(hbridge_pkg::STATE_OFFSET, 32'h29, 32'hFFFFFFFF, hbridge_pkg::RESP_OKAY);
        axw(hbridge_pkg::CONFIG_OFFSET, 32'h0, hbridge_pkg::RESP_OKAY);
        repeat (3) @(posedge core_clk);
        chk <= 1'b1;
        repeat (20) @(posedge core_clk);
        tallyAndFinish();
    end
endmodule
